// ### hw/adc_acquisition_conversion_ctrl.sv
/*
 * Acquisition and conversion sequencer with its control registers.
 * Assumes an 8-bit register port on SYS_CLK and a comparator that settles within one clock
 * of DAC_TRIAL, so it is read unsynchronised; two stages would outlast a two-cycle bit period.
 */
// Added by the designer: the register offsets and the plain strobed port.
// Contract
// RULE1: Format bit 7 set gives right justified result, clear gives left.
// RULE2: Acquisition codes map to 0,2,4,6,8,12,16,20 bit periods.
// RULE3: Clock codes select divide 2,8,32,RC,4,16,64,RC.
// RULE4: RC clock adds one instruction cycle before the bit clock runs.
// RULE5: Conversion continues while asleep when the RC clock is selected.
// RULE6: Reset clears control registers, powers off, abandons any conversion.
// RULE7: Completion loads result bytes, clears go, sets done flag.
// RULE8: Result bytes have no reset value.
// RULE9: Two bit periods pass after a conversion before acquisition resumes.
// RULE10: Nonzero acquisition code samples programmed periods, then converts.
// RULE11: Code zero converts immediately when go is set.
// RULE12: Software waits acquisition time in manual mode before setting go.
// RULE13: Acquisition field resets to the manual code.
// RULE14: After each conversion sampling of the selected channel resumes.
// RULE15: Go stays set through acquisition and conversion alike.
// RULE16: Holding capacitor stays disconnected for the whole conversion.
// RULE17: Result comes by successive approximation, one bit per period.
// RULE18: Software configures, powers on, sets go, then polls or waits.
// RULE19: Bit 6 of the timing register reads zero and ignores writes.
// RULE20: Go is bit 1 of the main control register.
// RULE21: Power bit enables the module when set.
// RULE22: Clearing go mid-conversion aborts without touching results.
// RULE23: A full conversion lasts eleven bit periods.
// RULE24: Justification pads with zeros above or below the ten bits.
// RULE25: Bit clock is a synchronous divider held stable through a sequence.
`timescale 1ns/1ps
module adc_acquisition_conversion_ctrl
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [2:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Device state
    input wire logic DEVICE_SLEEP,
    // Analog side
    input wire logic CMP_HIGH,
    output logic SAMPLE_EN,
    output logic HOLD_DISCONNECT,
    output logic [9:0] DAC_TRIAL,
    output logic [3:0] CHANNEL_SEL,
    // Events
    output logic CONVERSION_DONE_FLAG,
    output logic CONVERSION_IRQ
);
    typedef enum logic [4:0] {
        ST_OFF = 5'b00001,
        ST_SAMPLE = 5'b00010,
        ST_ACQ = 5'b00100,
        ST_CONV = 5'b01000,
        ST_REST = 5'b10000
    } seq_e;

    typedef struct packed {
        seq_e seq;
        logic [7:0] main_ctrl;
        logic [7:0] pin_ref;
        logic [7:0] timing_fmt;
        logic [4:0] periods;
        logic done_flag;
        logic irq_en;
        logic [7:0] rdata;
        logic sleep_meta;
        logic sleep_sync;
        logic sample;
        logic hold;
        logic irq;
        logic [2:0] clk_lock;
    } ctrl_state_s;

    ctrl_state_s st_ff;
    ctrl_state_s nxt_st;
    logic [7:0] res_hi_ff;
    logic [7:0] res_lo_ff;
    logic [7:0] nxt_res_hi;
    logic [7:0] nxt_res_lo;
    reg_req_s req;
    logic tick;
    logic sar_start;
    logic [9:0] trial;
    logic [9:0] sar_result;
    logic run;
    logic go;
    logic pwr;
    logic [2:0] acq_code;
    logic advance;

    function automatic logic [4:0] acq_periods(input logic [2:0] code);
        logic [4:0] p;
        p = 5'h00;
        unique case (code) // RULE2
            3'h0: p = 5'h00;
            3'h1: p = 5'h02;
            3'h2: p = 5'h04;
            3'h3: p = 5'h06;
            3'h4: p = 5'h08;
            3'h5: p = 5'h0C;
            3'h6: p = 5'h10;
            3'h7: p = 5'h14;
        endcase
        return p;
    endfunction : acq_periods

    function automatic logic [15:0] justify(input logic [9:0] r, input logic right);
        return right ? {6'h00, r} : {r, 6'h00}; // RULE1 RULE24
    endfunction : justify

    assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
    assign go = st_ff.main_ctrl[MAIN_GO_BIT];
    assign pwr = st_ff.main_ctrl[MAIN_POWER_BIT];
    assign acq_code = st_ff.timing_fmt[TF_ACQ_LSB +: 3];
    assign run = (st_ff.seq != ST_OFF) && (st_ff.seq != ST_SAMPLE || go);
    assign sar_start = (nxt_st.seq == ST_CONV) && (st_ff.seq != ST_CONV);
    // Sleep stops every bit clock except the internal RC one.
    assign advance = tick && (!st_ff.sleep_sync || st_ff.clk_lock[1:0] == 2'h3); // RULE5

    // The divider runs from SYS_CLK; the sleep input only gates progress.
    adc_tick_gen u_tick (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .run(run),
        .clk_sel(st_ff.clk_lock),
        .tick(tick)
    );

    adc_sar_core u_sar (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .start(sar_start),
        .step(advance && st_ff.seq == ST_CONV),
        .cmp_high(CMP_HIGH),
        .trial(trial),
        .result(sar_result)
    );

    // ==========================================================
    // Sequencer and registers
    always_comb
    begin
        logic [15:0] just;
        nxt_st = st_ff;
        nxt_res_hi = res_hi_ff;
        nxt_res_lo = res_lo_ff;
        just = justify(sar_result, st_ff.timing_fmt[TF_FORMAT_BIT]);
        nxt_st.sleep_meta = DEVICE_SLEEP;
        nxt_st.sleep_sync = st_ff.sleep_meta;
        nxt_st.rdata = 8'h00;
        if (req.rd)
        begin
            unique case (req.addr)
                OFS_MAIN_CTRL: nxt_st.rdata = st_ff.main_ctrl;
                OFS_PIN_REF_CTRL: nxt_st.rdata = st_ff.pin_ref;
                OFS_TIMING_FMT: nxt_st.rdata = st_ff.timing_fmt & MASK_TIMING_FMT; // RULE19
                OFS_RESULT_HIGH: nxt_st.rdata = res_hi_ff;
                OFS_RESULT_LOW: nxt_st.rdata = res_lo_ff;
                OFS_STATUS: nxt_st.rdata = {6'h00, st_ff.irq_en, st_ff.done_flag};
                default: nxt_st.rdata = 8'h00;
            endcase
        end
        if (req.wr)
        begin
            unique case (req.addr)
                OFS_MAIN_CTRL: nxt_st.main_ctrl = req.wdata & MASK_MAIN_CTRL; // RULE20
                OFS_PIN_REF_CTRL: nxt_st.pin_ref = req.wdata & MASK_PIN_REF_CTRL;
                OFS_TIMING_FMT: nxt_st.timing_fmt = req.wdata & MASK_TIMING_FMT; // RULE19
                OFS_RESULT_HIGH: nxt_res_hi = req.wdata;
                OFS_RESULT_LOW: nxt_res_lo = req.wdata;
                OFS_STATUS:
                begin
                    nxt_st.done_flag = req.wdata[ST_DONE_BIT];
                    nxt_st.irq_en = req.wdata[ST_IRQ_EN_BIT];
                end
                default: nxt_st.rdata = nxt_st.rdata;
            endcase
        end
        unique case (st_ff.seq)
            ST_OFF:
            begin
                nxt_st.sample = 1'b0;
                nxt_st.hold = 1'b0;
                if (pwr) // RULE21
                begin
                    nxt_st.seq = ST_SAMPLE;
                end
            end
            ST_SAMPLE:
            begin
                nxt_st.sample = 1'b1; // RULE14
                nxt_st.hold = 1'b0;
                nxt_st.clk_lock = st_ff.timing_fmt[TF_CLK_LSB +: 3]; // RULE25
                if (go && acq_code == ACQ_MANUAL)
                begin
                    nxt_st.seq = ST_CONV; // RULE11
                    nxt_st.periods = CONV_PERIODS;
                    nxt_st.sample = 1'b0;
                    nxt_st.hold = 1'b1;
                end
                else if (go)
                begin
                    nxt_st.seq = ST_ACQ; // RULE10
                    nxt_st.periods = acq_periods(acq_code);
                end
            end
            ST_ACQ:
            begin
                if (advance)
                begin
                    if (st_ff.periods == 5'h01)
                    begin
                        nxt_st.seq = ST_CONV;
                        nxt_st.periods = CONV_PERIODS;
                        nxt_st.sample = 1'b0;
                        nxt_st.hold = 1'b1; // RULE16
                    end
                    else
                    begin
                        nxt_st.periods = st_ff.periods - 5'h01;
                    end
                end
            end
            ST_CONV:
            begin
                if (advance)
                begin
                    if (st_ff.periods == 5'h01) // RULE23
                    begin
                        nxt_st.seq = ST_REST;
                        nxt_st.periods = RESUME_PERIODS;
                        nxt_st.hold = 1'b0;
                        nxt_res_hi = just[15:8]; // RULE7
                        nxt_res_lo = just[7:0];
                        nxt_st.main_ctrl[MAIN_GO_BIT] = 1'b0;
                        nxt_st.done_flag = 1'b1;
                    end
                    else
                    begin
                        nxt_st.periods = st_ff.periods - 5'h01;
                    end
                end
            end
            ST_REST:
            begin
                if (advance)
                begin
                    if (st_ff.periods == 5'h01) // RULE9
                    begin
                        nxt_st.seq = ST_SAMPLE;
                    end
                    else
                    begin
                        nxt_st.periods = st_ff.periods - 5'h01;
                    end
                end
            end
        endcase
        // Go cleared by software during acquisition or conversion aborts it.
        if ((st_ff.seq == ST_ACQ || st_ff.seq == ST_CONV) && !go) // RULE22
        begin
            nxt_st.seq = ST_REST;
            nxt_st.periods = RESUME_PERIODS;
            nxt_st.hold = 1'b0;
            nxt_res_hi = res_hi_ff;
            nxt_res_lo = res_lo_ff;
        end
        if (!nxt_st.main_ctrl[MAIN_POWER_BIT])
        begin
            nxt_st.seq = ST_OFF;
            nxt_st.sample = 1'b0;
            nxt_st.hold = 1'b0;
        end
        nxt_st.irq = nxt_st.done_flag && nxt_st.irq_en;
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            st_ff <= '0; // RULE6
            st_ff.seq <= ST_OFF;
            st_ff.main_ctrl <= RST_MAIN_CTRL;
            st_ff.pin_ref <= RST_PIN_REF_CTRL;
            st_ff.timing_fmt <= RST_TIMING_FMT; // RULE13
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Result bytes hold their content across reset.
    always_ff @(posedge SYS_CLK)
    begin
        res_hi_ff <= nxt_res_hi; // RULE8
        res_lo_ff <= nxt_res_lo;
    end

    assign REG_RDATA = st_ff.rdata;
    assign SAMPLE_EN = st_ff.sample;
    assign HOLD_DISCONNECT = st_ff.hold;
    assign DAC_TRIAL = trial;
    assign CHANNEL_SEL = st_ff.main_ctrl[5:2];
    assign CONVERSION_DONE_FLAG = st_ff.done_flag;
    assign CONVERSION_IRQ = st_ff.irq;

    // ==========================================================
    // Checks
    property p_hold_through_conv;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (st_ff.seq == ST_CONV) |-> HOLD_DISCONNECT && !SAMPLE_EN;
    endproperty
    a_hold_through_conv: assert property (p_hold_through_conv) // RULE16
        else $error("Holding capacitor connected during conversion.");
    property p_done_clears_go;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (st_ff.seq == ST_CONV && $past(st_ff.seq) == ST_CONV) ##1 (st_ff.seq == ST_REST && go == 1'b0 && $past(go))
        |-> CONVERSION_DONE_FLAG;
    endproperty
    a_done_clears_go: assert property (p_done_clears_go) // RULE7
        else $error("Completion without done flag.");
    property p_go_held;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (st_ff.seq == ST_ACQ && !(REG_WR && REG_ADDR == OFS_MAIN_CTRL)) |=> go || st_ff.seq == ST_OFF;
    endproperty
    a_go_held: assert property (p_go_held) // RULE15
        else $error("Go dropped during acquisition.");
    property p_bit6_zero;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        st_ff.timing_fmt[6] == 1'b0;
    endproperty
    a_bit6_zero: assert property (p_bit6_zero) // RULE19
        else $error("Unimplemented bit set.");
    property p_manual_immediate;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (st_ff.seq == ST_SAMPLE && go && acq_code == ACQ_MANUAL && pwr) |=> st_ff.seq == ST_CONV;
    endproperty
    a_manual_immediate: assert property (p_manual_immediate) // RULE11
        else $error("Manual conversion did not start at once.");
    property p_power_off;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        !pwr |-> st_ff.seq == ST_OFF;
    endproperty
    a_power_off: assert property (p_power_off) // RULE21
        else $error("Sequencer active while powered off.");
    property p_conv_len;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        $rose(st_ff.seq == ST_CONV) |-> st_ff.periods == CONV_PERIODS;
    endproperty
    a_conv_len: assert property (p_conv_len) // RULE23
        else $error("Conversion length wrong.");
    property p_rest_len;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        $rose(st_ff.seq == ST_REST) |-> st_ff.periods == RESUME_PERIODS;
    endproperty
    a_rest_len: assert property (p_rest_len) // RULE9
        else $error("Rest period wrong.");
endmodule : adc_acquisition_conversion_ctrl

// ### hw/adc_seq_pkg.sv
/*
 * Constants, field layouts and carrier types for the converter sequencer.
 * Assumes a 20 MHz system clock and an 8-bit register port.
 */
package adc_seq_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [2:0] OFS_MAIN_CTRL = 3'h0;
    localparam logic [2:0] OFS_PIN_REF_CTRL = 3'h1;
    localparam logic [2:0] OFS_TIMING_FMT = 3'h2;
    localparam logic [2:0] OFS_RESULT_HIGH = 3'h3;
    localparam logic [2:0] OFS_RESULT_LOW = 3'h4;
    localparam logic [2:0] OFS_STATUS = 3'h5;
    // ==========================================================
    // Field positions
    localparam int MAIN_POWER_BIT = 0;
    localparam int MAIN_GO_BIT = 1;
    localparam int TF_FORMAT_BIT = 7;
    localparam int TF_ACQ_LSB = 3;
    localparam int TF_CLK_LSB = 0;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_IRQ_EN_BIT = 1;
    // ==========================================================
    // Reset values and masks
    localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
    localparam logic [7:0] RST_PIN_REF_CTRL = 8'h00;
    localparam logic [7:0] RST_TIMING_FMT = 8'h00;
    localparam logic [7:0] MASK_MAIN_CTRL = 8'h3F;
    localparam logic [7:0] MASK_PIN_REF_CTRL = 8'h3F;
    localparam logic [7:0] MASK_TIMING_FMT = 8'hBF;
    localparam logic [2:0] ACQ_MANUAL = 3'h0;
    // ==========================================================
    // Timing counts in bit-conversion periods, clock rates and system-clock cycles
    localparam logic [4:0] CONV_PERIODS = 5'h0B;
    localparam logic [4:0] RESUME_PERIODS = 5'h02;
    localparam int SYS_CLK_HZ = 20000000;
    localparam int INSTR_CLK_DIV = 4;
    localparam int RC_TICK_NS = 1200;
    localparam int SYS_PERIOD_NS = 1000000000 / SYS_CLK_HZ;
    localparam logic [7:0] RC_START_CYCLES = 8'(INSTR_CLK_DIV);
    localparam logic [7:0] RC_PERIOD_CYCLES = 8'(RC_TICK_NS / SYS_PERIOD_NS);
    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
    typedef struct packed {
        logic sample;
        logic hold;
        logic [9:0] trial;
    } analog_ctl_s;
endpackage : adc_seq_pkg

// ### hw/adc_tick_gen.sv
/*
 * Bit-period tick generator for the converter.
 * Assumes the caller holds the clock select stable while run is high.
 */
`timescale 1ns/1ps
module adc_tick_gen
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [2:0] clk_sel,
    // Tick out
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic started;
        logic tick;
    } tick_state_s;

    tick_state_s st_ff;
    tick_state_s nxt_st;

    function automatic logic [7:0] period_of(input logic [2:0] sel);
        logic [7:0] p;
        p = RC_PERIOD_CYCLES;
        unique case (sel)
            3'h0: p = 8'h02;
            3'h1: p = 8'h08;
            3'h2: p = 8'h20;
            3'h4: p = 8'h04;
            3'h5: p = 8'h10;
            3'h6: p = 8'h40;
            default: p = RC_PERIOD_CYCLES;
        endcase
        return p;
    endfunction : period_of

    // ==========================================================
    // Divider
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (!run)
        begin
            nxt_st.cnt = 8'h00;
            nxt_st.started = 1'b0;
        end
        else if (!st_ff.started)
        begin
            if (st_ff.cnt + 8'h01 >= ((clk_sel[1:0] == 2'h3) ? RC_START_CYCLES : 8'h01)) // RULE4
            begin
                nxt_st.started = 1'b1;
                nxt_st.cnt = 8'h00;
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt + 8'h01;
            end
        end
        else if (st_ff.cnt + 8'h01 >= period_of(clk_sel)) // RULE3 RULE25
        begin
            nxt_st.cnt = 8'h00;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;
endmodule : adc_tick_gen

// ### hw/adc_sar_core.sv
/*
 * Successive-approximation register, one bit per tick.
 * Assumes the comparator input is synchronous to clk.
 */
`timescale 1ns/1ps
module adc_sar_core
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic step,
    input wire logic cmp_high,
    // Result
    output logic [9:0] trial,
    output logic [9:0] result
);
    typedef struct packed {
        logic [9:0] trial;
        logic [9:0] bitmask;
    } sar_state_s;

    sar_state_s st_ff;
    sar_state_s nxt_st;

    // ==========================================================
    // Bit resolution
    always_comb
    begin
        nxt_st = st_ff;
        if (start)
        begin
            nxt_st.trial = 10'h200;
            nxt_st.bitmask = 10'h200;
        end
        else if (step && st_ff.bitmask != 10'h000) // RULE17
        begin
            nxt_st.trial = cmp_high ? st_ff.trial : (st_ff.trial & ~st_ff.bitmask);
            nxt_st.bitmask = st_ff.bitmask >> 1;
            if (st_ff.bitmask != 10'h001)
            begin
                nxt_st.trial = nxt_st.trial | (st_ff.bitmask >> 1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign trial = st_ff.trial;
    assign result = st_ff.trial;
endmodule : adc_sar_core

// ### verification/adc_analog_model.sv
/*
 * Analog front end: sampling switch, hold capacitor and comparator.
 * Assumes the sequencer drives the switch controls from the same clock.
 */
`timescale 1ns/1ps
module adc_analog_model
(
    // Clock and switch controls
    input wire logic clk,
    input wire logic sample_en,
    input wire logic hold_disc,
    input wire logic [9:0] trial,
    input wire logic [9:0] vin,
    // Comparator
    output logic cmp_high
);
    // ==========================================================
    // Hold capacitor and comparator
    logic [9:0] held = 10'h000;
    logic flip = 1'b0;
    always @(posedge clk)
    begin
        flip <= ~flip;
        if (sample_en && !hold_disc)
            held <= vin;
    end
    // Outside the hold phase the comparator output is meaningless.
    assign cmp_high = hold_disc ? (held >= trial) : flip;
endmodule : adc_analog_model

// ### verification/adc_acquisition_conversion_ctrl_tb_top.sv
/*
 * Self-checking bench for the converter sequencer.
 * Assumes the analog model in adc_analog_model.sv.
 */
`timescale 1ns/1ps
module adc_acquisition_conversion_ctrl_tb_top;
    import adc_seq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_s req = '0;
    logic sleep = 1'b0;
    logic [9:0] vin = 10'h000;
    logic cmp, samp, hold, done, irq;
    logic [9:0] trial;
    logic [3:0] chan;
    logic [7:0] rdata, rv;
    logic [31:0] st = 32'h51;
    logic [15:0] exp_res = 16'h0000;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    int d, base;
    int acq_ticks[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int clk_div[8] = '{2, 8, 32, RC_PERIOD_CYCLES, 4, 16, 64, RC_PERIOD_CYCLES};
    always #25 clk = ~clk;
    // ==========================================================
    // Design and partner
    adc_acquisition_conversion_ctrl i_adc_acquisition_conversion_ctrl (
        .SYS_CLK(clk), .RESET_N(rst_n), .REG_ADDR(req.addr), .REG_WDATA(req.wdata),
        .REG_WR(req.wr), .REG_RD(req.rd), .REG_RDATA(rdata), .DEVICE_SLEEP(sleep),
        .CMP_HIGH(cmp), .SAMPLE_EN(samp), .HOLD_DISCONNECT(hold), .DAC_TRIAL(trial),
        .CHANNEL_SEL(chan), .CONVERSION_DONE_FLAG(done), .CONVERSION_IRQ(irq));
    adc_analog_model i_adc_analog_model (.clk(clk), .sample_en(samp),
        .hold_disc(hold), .trial(trial), .vin(vin), .cmp_high(cmp));
    // ==========================================================
    // Tasks
    function logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task test_done();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task check(input logic [15:0] got, input logic [15:0] want);
        tests_run++;
        if (got !== want)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check
    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask : wr
    task rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1 v = rdata;
    endtask : rd
    task conv(input logic [7:0] tf);
        repeat (150) @(posedge clk);
        st = xs(st);
        vin <= st[9:0];
        wr(OFS_TIMING_FMT, tf);
        wr(OFS_STATUS, 8'h02);
        wr(OFS_MAIN_CTRL, 8'h01);
        wr(OFS_MAIN_CTRL, 8'h03);
        d = 0;
        while (done !== 1'b1 && d < 3000)
        begin
            @(posedge clk);
            #1 d++;
        end
        exp_res = tf[7] ? {6'h00, vin} : {vin, 6'h00};
        check(irq, 1'b1);
        rd(OFS_MAIN_CTRL, rv);
        check(rv, 8'h01);
        rd(OFS_RESULT_HIGH, rv);
        check(rv, exp_res[15:8]);
        rd(OFS_RESULT_LOW, rv);
        check(rv, exp_res[7:0]);
        repeat (140) @(posedge clk);
        #1 check(samp, 1'b1);
    endtask : conv
    // ==========================================================
    // Timeout
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            test_done();
        end
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_TIMING_FMT, rv);
        check(rv, 8'h00);
        rd(OFS_MAIN_CTRL, rv);
        check(rv, 8'h00);
        wr(OFS_TIMING_FMT, 8'hFF);
        rd(OFS_TIMING_FMT, rv);
        check(rv, 8'hBF);
        rd(3'h7, rv);
        check(rv, 8'h00);
        wr(OFS_MAIN_CTRL, 8'hFC);
        rd(OFS_MAIN_CTRL, rv);
        check(rv, 8'h3C);
        check(chan, 4'hF);
        $display("test registers done");
        for (int s = 0; s < 8; s++)
        begin
            conv({s[0], 4'h0, s[2:0]});
            check(d >= 11 * clk_div[s] && d <= 12 * clk_div[s] + 8, 1'b1);
        end
        $display("test clock select done");
        conv(8'h80);
        base = d;
        for (int c = 1; c < 8; c++)
        begin
            conv({2'b10, c[2:0], 3'h0});
            check(d - base, acq_ticks[c] * clk_div[0]);
        end
        $display("test acquisition done");
        @(posedge clk);
        sleep <= 1'b1;
        conv(8'h83);
        @(posedge clk);
        sleep <= 1'b0;
        $display("test sleep done");
        wr(OFS_TIMING_FMT, 8'h86);
        wr(OFS_STATUS, 8'h02);
        vin <= ~vin;
        wr(OFS_MAIN_CTRL, 8'h03);
        repeat (300) @(posedge clk);
        wr(OFS_MAIN_CTRL, 8'h01);
        repeat (300) @(posedge clk);
        check(done, 1'b0);
        rd(OFS_RESULT_HIGH, rv);
        check(rv, exp_res[15:8]);
        rd(OFS_RESULT_LOW, rv);
        check(rv, exp_res[7:0]);
        $display("test abort done");
        wr(OFS_MAIN_CTRL, 8'h03);
        repeat (100) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_MAIN_CTRL, rv);
        check(rv, 8'h00);
        rd(OFS_TIMING_FMT, rv);
        check(rv, 8'h00);
        check(done, 1'b0);
        rd(OFS_RESULT_HIGH, rv);
        check(rv, exp_res[15:8]);
        rd(OFS_RESULT_LOW, rv);
        check(rv, exp_res[7:0]);
        $display("test reset done");
        test_done();
    end
endmodule : adc_acquisition_conversion_ctrl_tb_top
